/* logic/spc_pkg.sv */
// Constants for the single-pair medium attachment control register bank.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
package spc_pkg;
    // Register indices, not byte addresses: the bus address is four times the index without its group nibble
    localparam logic [15:0] SPC_IDX_EXT_ABILITY = 16'h1012;
    localparam logic [15:0] SPC_IDX_ROLE_TYPE   = 16'h1834;
    localparam logic [15:0] SPC_IDX_LAYER_CTRL  = 16'h18F6;
    localparam int          SPC_GROUP_LSB       = 12;
    localparam logic [3:0]  SPC_GROUP_NIBBLE    = 4'h1;
    localparam logic [15:0] SPC_EXT_ABILITY_RST = 16'h0004;
    localparam logic [15:0] SPC_ROLE_TYPE_RST   = 16'h4002;
    localparam logic [15:0] SPC_LAYER_CTRL_RST  = 16'h0000;
    localparam int          SPC_ROLE_BIT        = 14;
    localparam logic [3:0]  SPC_TYPE_CODE       = 4'h2;
    localparam int          SPC_RESET_BIT       = 15;
    localparam int          SPC_TXDIS_BIT       = 14;
    localparam int          SPC_AMPL_BIT        = 12;
    localparam int          SPC_LOWPWR_BIT      = 11;
    localparam int          SPC_EEE_BIT         = 10;
    localparam int          SPC_LOOP_BIT        = 0;
    localparam logic [15:0] SPC_LAYER_WMASK     = 16'h5C01;
    localparam logic [1:0]  SPC_RESP_OKAY       = 2'b00;
    localparam logic [1:0]  SPC_RESP_SLVERR     = 2'b10;
    localparam int          SPC_LAYER_RST_CYCLES = 4;
endpackage : spc_pkg

/* logic/spc_pulse.sv */
// Stretches a one-cycle request into a fixed-length reset pulse.
// Assumes a single synchronous clock domain.
`timescale 1ns/100ps
module spc_pulse #(
    parameter int LEN = 4
) (
    input  wire logic CLK,
    input  wire logic SRST,
    input  wire logic start,
    output logic      busy
);
    logic [7:0] cnt_r;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_r <= 8'h00;
        end else if (start) begin
            cnt_r <= 8'(LEN);
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    assign busy = (cnt_r != 8'h00);
endmodule : spc_pulse

/* logic/spc_regs.sv */
// AXI4-Lite register bank for the single-pair medium attachment control.
// Assumes one clock, synchronous reset; role and mode bits reach the datapath through one register stage.
// Behaviour
// - Ability register reports long-reach capability bit
// - Role bit selects leader or follower
// - Layer reset bit self-clears after pulse
// - Transmit disable bit, read and write
// - Amplitude bit selects 2.4 or 1.0 Vpp
// - Low-power bit, read and write
// - Energy-efficient mode enable bit
// - Loopback enable bit, read and write
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module spc_regs (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [31:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic             LEADER_ROLE,
    output logic             LAYER_RESET,
    output logic             TX_DISABLE,
    output logic             HIGH_AMPLITUDE,
    output logic             LOW_POWER,
    output logic             EEE_ENABLE,
    output logic             LOOPBACK
);
    // Index match; the group nibble is already stripped by software, so compare low 12 bits
    function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
        hit = (addr[1:0] == 2'b00) && (addr[13:2] == idx[11:0]) && (addr[31:14] == 18'h00000);
    endfunction : hit

    logic        aw_held_r, w_held_r;
    logic [31:0] awaddr_r, wdata_r;
    logic [3:0]  wstrb_r;
    logic        role_r;
    logic [15:0] layer_r, layer_nxt;
    logic [31:0] rdata_nxt;
    logic        rd_ok;
    logic        rst_busy;

    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take  = S_AXI_WVALID && S_AXI_WREADY;
    wire do_wr   = aw_held_r && w_held_r && !S_AXI_BVALID;
    wire wr_role = do_wr && hit(awaddr_r, spc_pkg::SPC_IDX_ROLE_TYPE);
    wire wr_lay  = do_wr && hit(awaddr_r, spc_pkg::SPC_IDX_LAYER_CTRL);
    wire wr_ok   = hit(awaddr_r, spc_pkg::SPC_IDX_EXT_ABILITY) || wr_role || wr_lay;
    wire wr_lo   = wstrb_r[0];
    wire wr_hi   = wstrb_r[1];
    wire rst_req = wr_lay && wr_hi && wdata_r[spc_pkg::SPC_RESET_BIT];
    wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;

    wire [15:0] lay_wmask = spc_pkg::SPC_LAYER_WMASK & {{8{wr_hi}}, {8{wr_lo}}};
    assign layer_nxt = (layer_r & ~lay_wmask) | (wdata_r[15:0] & lay_wmask);

    wire [15:0] role_word = {1'b0, role_r, 10'h000, spc_pkg::SPC_TYPE_CODE};
    wire [15:0] lay_word  = {rst_busy, layer_r[14:0]};

    assign rd_ok = hit(S_AXI_ARADDR, spc_pkg::SPC_IDX_EXT_ABILITY)
                || hit(S_AXI_ARADDR, spc_pkg::SPC_IDX_ROLE_TYPE)
                || hit(S_AXI_ARADDR, spc_pkg::SPC_IDX_LAYER_CTRL);
    assign rdata_nxt =
        hit(S_AXI_ARADDR, spc_pkg::SPC_IDX_EXT_ABILITY)
            ? {16'h0000, spc_pkg::SPC_EXT_ABILITY_RST}
      : hit(S_AXI_ARADDR, spc_pkg::SPC_IDX_ROLE_TYPE)   ? {16'h0000, role_word}
      : hit(S_AXI_ARADDR, spc_pkg::SPC_IDX_LAYER_CTRL)  ? {16'h0000, lay_word}
      : 32'h00000000;

    // Stretched internal reset; the bit reads 1 while it runs, then clears itself
    spc_pulse #(.LEN(spc_pkg::SPC_LAYER_RST_CYCLES)) u_pulse (
        .CLK   (CLK),
        .SRST  (SRST),
        .start (rst_req),
        .busy  (rst_busy)
    );

    // Write address and data channels, taken in either order
    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= 32'h00000000;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_held_r && !aw_take;
            S_AXI_WREADY  <= !w_held_r && !w_take;
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= S_AXI_AWADDR;
            end else if (do_wr) begin
                aw_held_r <= 1'b0;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r  <= S_AXI_WDATA;
                wstrb_r  <= S_AXI_WSTRB;
            end else if (do_wr) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= spc_pkg::SPC_RESP_OKAY;
        end else if (do_wr) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_ok ? spc_pkg::SPC_RESP_OKAY : spc_pkg::SPC_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            role_r  <= spc_pkg::SPC_ROLE_TYPE_RST[spc_pkg::SPC_ROLE_BIT];
            layer_r <= spc_pkg::SPC_LAYER_CTRL_RST;
        end else begin
            if (wr_role && wr_hi) begin
                role_r <= wdata_r[spc_pkg::SPC_ROLE_BIT];
            end
            if (wr_lay) begin
                layer_r <= layer_nxt;
            end
        end
    end

    // Read channel: one outstanding read, answer one cycle after address
    always_ff @(posedge CLK) begin
        if (SRST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= spc_pkg::SPC_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !rd_take && !S_AXI_ARREADY;
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rdata_nxt;
                S_AXI_RRESP  <= rd_ok ? spc_pkg::SPC_RESP_OKAY : spc_pkg::SPC_RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Control outputs registered so the datapath sees clean levels
    always_ff @(posedge CLK) begin
        if (SRST) begin
            LEADER_ROLE    <= 1'b1;
            LAYER_RESET    <= 1'b0;
            TX_DISABLE     <= 1'b0;
            HIGH_AMPLITUDE <= 1'b0;
            LOW_POWER      <= 1'b0;
            EEE_ENABLE     <= 1'b0;
            LOOPBACK       <= 1'b0;
        end else begin
            LEADER_ROLE    <= role_r;
            LAYER_RESET    <= rst_busy;
            TX_DISABLE     <= layer_r[spc_pkg::SPC_TXDIS_BIT];
            HIGH_AMPLITUDE <= layer_r[spc_pkg::SPC_AMPL_BIT];
            LOW_POWER      <= layer_r[spc_pkg::SPC_LOWPWR_BIT];
            EEE_ENABLE     <= layer_r[spc_pkg::SPC_EEE_BIT];
            LOOPBACK       <= layer_r[spc_pkg::SPC_LOOP_BIT];
        end
    end

    property p_ability;
        @(posedge CLK) disable iff (SRST)
        rd_take && hit(S_AXI_ARADDR, spc_pkg::SPC_IDX_EXT_ABILITY) |=> S_AXI_RDATA == 32'h00000004;
    endproperty
    a_ability: assert property (p_ability) else $error("ability word wrong");

    property p_role;
        @(posedge CLK) disable iff (SRST)
        wr_role && wr_hi |=> ##1 LEADER_ROLE == $past(wdata_r[14], 2);
    endproperty
    a_role: assert property (p_role) else $error("role not applied");

    property p_selfclear;
        @(posedge CLK) disable iff (SRST)
        rst_req |=> rst_busy [*4];
    endproperty
    a_selfclear: assert property (p_selfclear) else $error("layer reset length wrong");

    // A repeated request restarts the pulse, so the end is only checked for a lone one
    property p_pulse_end;
        @(posedge CLK) disable iff (SRST)
        rst_req ##1 (!rst_req) [*4] |=> !rst_busy;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("layer reset not cleared");

    property p_txdis;
        @(posedge CLK) disable iff (SRST)
        wr_lay && wr_hi |=> ##1 TX_DISABLE == $past(wdata_r[14], 2);
    endproperty
    a_txdis: assert property (p_txdis) else $error("transmit disable wrong");

    property p_ampl;
        @(posedge CLK) disable iff (SRST)
        wr_lay && wr_hi |=> ##1 HIGH_AMPLITUDE == $past(wdata_r[12], 2);
    endproperty
    a_ampl: assert property (p_ampl) else $error("amplitude wrong");

    property p_lowpwr;
        @(posedge CLK) disable iff (SRST)
        !wr_lay |=> ##1 LOW_POWER == $past(LOW_POWER);
    endproperty
    a_lowpwr: assert property (p_lowpwr) else $error("low power changed unasked");

    property p_eee;
        @(posedge CLK) disable iff (SRST)
        wr_lay && wr_hi |=> ##1 EEE_ENABLE == $past(wdata_r[10], 2);
    endproperty
    a_eee: assert property (p_eee) else $error("eee enable wrong");

    property p_loop;
        @(posedge CLK) disable iff (SRST)
        wr_lay && wr_lo |=> ##1 LOOPBACK == $past(wdata_r[0], 2);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback wrong");

    property p_reserved;
        @(posedge CLK) disable iff (SRST)
        (layer_r & ~spc_pkg::SPC_LAYER_WMASK) == 16'h0000 && S_AXI_RDATA[31:16] == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
endmodule : spc_regs

/* dv/spc_host.sv */
// Management-side model: AXI4-Lite master making one access at a time.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/100ps
module spc_host (
    input  wire logic        clk,
    output logic [31:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [31:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'h0;
    end
    // Released payloads are inverted so a stale value never looks valid
    task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= {16'h0, d};
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awready) begin
                pa = 1'b0;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (pw && wready) begin
                pw = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~{16'h0, d};
            end
        end
        while (!bvalid) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] q, output logic [1:0] r);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        while (!rvalid) @(posedge clk);
        q = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd
endmodule : spc_host

/* dv/spc_testbench.sv */
// Self-checking bench for the medium attachment control register bank.
// Assumes the host model is the only bus master; control outputs are watched here.
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module testbench;
    logic clk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, lead, lrst, txd, hamp, lpw, eee, loop;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [4:0]  ctl;
    int          failures, tests_run;
    // Group nibble stripped, then index times four
    localparam logic [31:0] A_ABL = 32'h0000_0048;
    localparam logic [31:0] A_ROLE = 32'h0000_20D0;
    localparam logic [31:0] A_CTL = 32'h0000_23D8;
    assign ctl = {txd, hamp, lpw, eee, loop};
    spc_regs dut_u (.CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .LEADER_ROLE(lead), .LAYER_RESET(lrst), .TX_DISABLE(txd), .HIGH_AMPLITUDE(hamp),
        .LOW_POWER(lpw), .EEE_ENABLE(eee), .LOOPBACK(loop));
    spc_host host_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    task automatic wchk(input logic [31:0] a, input logic [15:0] d);
        host_u.wr(a, d, 4'hF, r);
        `CHK("bresp", spc_pkg::SPC_RESP_OKAY, r)
    endtask : wchk
    task automatic rchk(input logic [31:0] a, input logic [15:0] e);
        logic [31:0] q;
        host_u.rd(a, q, r);
        `CHK("rresp", spc_pkg::SPC_RESP_OKAY, r)
        `CHK("rdata", {16'h0, e}, q)
    endtask : rchk
    task automatic t_reset();
        rchk(A_ABL, 16'h0004);
        rchk(A_ROLE, 16'h4002);
        rchk(A_CTL, 16'h0000);
        `CHK("role", 1'b1, lead)
        `CHK("ctl", 5'h00, ctl)
    endtask : t_reset
    task automatic t_role();
        wchk(A_ABL, 16'hFFFF);
        rchk(A_ABL, 16'h0004);
        wchk(A_ROLE, 16'h0000);
        rchk(A_ROLE, 16'h0002);
        `CHK("role", 1'b0, lead)
        wchk(A_ROLE, 16'hFFFF);
        rchk(A_ROLE, 16'h4002);
        `CHK("role", 1'b1, lead)
    endtask : t_role
    task automatic t_bits();
        int b[5] = '{14, 12, 11, 10, 0};
        for (int i = 0; i < 5; i++) begin
            wchk(A_CTL, 16'h0001 << b[i]);
            rchk(A_CTL, 16'h0001 << b[i]);
            `CHK("ctl", 5'h10 >> i, ctl)
        end
        wchk(A_CTL, 16'h7FFF);
        rchk(A_CTL, 16'h5C01);
        `CHK("ctl", 5'h1F, ctl)
        // Upper lane only: bits 15:8 clear, loopback in the lower lane stays
        host_u.wr(A_CTL, 16'h0000, 4'h2, r);
        `CHK("bresp", spc_pkg::SPC_RESP_OKAY, r)
        rchk(A_CTL, 16'h0001);
        `CHK("ctl", 5'h01, ctl)
    endtask : t_bits
    task automatic t_lrst();
        int n;
        n = 0;
        fork
            wchk(A_CTL, 16'h8001);
            repeat (30) begin
                @(posedge clk);
                n += lrst;
            end
        join
        `CHK("pulse", spc_pkg::SPC_LAYER_RST_CYCLES, n)
        rchk(A_CTL, 16'h0001);
    endtask : t_lrst
    task automatic t_bad();
        logic [31:0] q;
        host_u.wr(32'h0000_23DC, 16'hFFFF, 4'hF, r);
        `CHK("bresp", spc_pkg::SPC_RESP_SLVERR, r)
        host_u.rd(32'h0000_23D9, q, r);
        `CHK("rresp", spc_pkg::SPC_RESP_SLVERR, r)
        `CHK("rdata", 32'h0, q)
        rchk(A_CTL, 16'h0001);
    endtask : t_bad
    task automatic t_srst();
        wchk(A_ROLE, 16'h0000);
        wchk(A_CTL, 16'h5C01);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        rchk(A_ROLE, 16'h4002);
        rchk(A_CTL, 16'h0000);
        `CHK("role", 1'b1, lead)
        `CHK("ctl", 5'h00, ctl)
    endtask : t_srst
    task automatic final_report();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        srst = 1'b1;
        failures = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_role();
        t_bits();
        t_lrst();
        t_bad();
        t_srst();
        final_report();
    end
    // Whole run needs under two hundred cycles; allow 5000, over twenty-five times that
    initial begin
        #(25 * 5000);
        failures++;
        final_report();
    end
endmodule : testbench
